// ### rtl/dbss_defs.svh
`ifndef DBSS_DEFS_SVH
`define DBSS_DEFS_SVH

// Clock and braking time base
`define DBSS_CLK_NS 50
`define DBSS_TICK_NS 100000000
`define DBSS_TICK_CYCLES (`DBSS_TICK_NS / `DBSS_CLK_NS)

// Register byte offsets
`define DBSS_OFS_CTRL 8'h00
`define DBSS_OFS_BFREQ 8'h04
`define DBSS_OFS_SFREQ 8'h08
`define DBSS_OFS_BDUR 8'h0C
`define DBSS_OFS_VOLT 8'h10
`define DBSS_OFS_TUNE 8'h14
`define DBSS_OFS_STAT 8'h18
`define DBSS_OFS_TERM0 8'h40
`define DBSS_OFS_TERM_LAST 8'h6C

// Control and tuning register fields
`define DBSS_CTRL_METHOD_BIT 4
`define DBSS_CTRL_PRE_BIT 5
`define DBSS_TUNE2_LSB 8

// Frequencies in 0.01 Hz steps
`define DBSS_BFREQ_RST 16'h012C
`define DBSS_BFREQ_VEC 16'h0032
`define DBSS_BFREQ_SPECIAL 16'h270F
`define DBSS_SFREQ_RST 16'h0032

// Duration in 0.1 s steps
`define DBSS_BDUR_RST 14'h0005
`define DBSS_BDUR_MAX 14'h0064
`define DBSS_BDUR_HELD 14'h22B8

// Injection voltage percent
`define DBSS_VOLT_SMALL 5'h04
`define DBSS_VOLT_LARGE 5'h02
`define DBSS_VOLT_MAX 5'h1E

// Terminal function codes
`define DBSS_NTERM 12
`define DBSS_FN_BRAKE_REQ 8'h0D
`define DBSS_FN_SECOND 8'h03
`define DBSS_FN_NONE 8'hFF

`endif

// ### rtl/dbss_pkg.sv
package dbss_pkg;

	typedef enum logic [1:0] {CTRL_VF, CTRL_AMF, CTRL_SLV, CTRL_VEC} dbss_ctrl_type;
	typedef enum logic [1:0] {KIND_NONE, KIND_DC, KIND_ZERO, KIND_SERVO} dbss_kind_type;
	typedef enum logic [1:0] {TUNE_OFF, TUNE_START, TUNE_OBSERVER} dbss_tune_type;
	typedef enum logic [1:0] {SEQ_RUN, SEQ_TIMED, SEQ_HELD, SEQ_DONE} dbss_seq_type;

	typedef struct packed {
		logic decel;
		logic [15:0] out_freq;
	} dbss_drive_type;

	typedef struct packed {
		logic active;
		logic coast;
		dbss_kind_type kind;
		logic [4:0] volt;
	} dbss_brake_type;

	typedef struct packed {
		logic [11:0][7:0] mem;
		logic [7:0] rdata;
	} dbss_mem_state_type;

	typedef struct packed {
		logic [11:0] term_m;
		logic [11:0] term_s;
		logic rt_m;
		logic rt_s;
		logic enc_m;
		logic enc_s;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		dbss_ctrl_type ctrl;
		logic method;
		logic pre;
		logic [15:0] bfreq;
		logic bfreq_wr;
		logic [15:0] sfreq;
		logic [13:0] dur;
		logic [4:0] volt;
		dbss_tune_type tune1;
		dbss_tune_type tune2;
		logic [3:0] scan_idx;
		logic rd_scan;
		logic [3:0] rd_idx;
		logic [11:0] x13_map;
		logic [11:0] rt_map;
		dbss_seq_type seq;
		logic [20:0] tick;
		logic [6:0] remain;
		dbss_brake_type brake;
		logic second_fn;
		dbss_tune_type tune_out;
	} dbss_state_type;

endpackage

// ### rtl/dbss_term_mem.sv
`timescale 1ns/1ps
`include "dbss_defs.svh"
module dbss_term_mem
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Write port
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [7:0] wr_data,
	// Registered read port
	input wire logic [3:0] rd_idx,
	output logic [7:0] rd_data
);
	import dbss_pkg::*;

	dbss_mem_state_type st_ff;
	dbss_mem_state_type nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		if (wr_en && wr_idx < 4'(`DBSS_NTERM))
			nxt_st.mem[wr_idx] = wr_data;
		// Out-of-range index reads as no function
		nxt_st.rdata = (rd_idx < 4'(`DBSS_NTERM)) ? st_ff.mem[rd_idx] : `DBSS_FN_NONE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= '{mem: {`DBSS_NTERM{`DBSS_FN_NONE}}, rdata: `DBSS_FN_NONE};
		else
			st_ff <= nxt_st;
	end

	assign rd_data = st_ff.rdata;
endmodule

// ### rtl/dbss_top.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "dbss_defs.svh"
module dbss_top
#(
	parameter int TICK_CYCLES = `DBSS_TICK_CYCLES,
	parameter bit LARGE_RATING = 1'b0
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive status, same clock
	input wire dbss_pkg::dbss_drive_type drive,
	// Pins
	input wire logic [11:0] term_pins,
	input wire logic second_fn_pin,
	input wire logic encoder_fitted,
	// Results
	output dbss_pkg::dbss_brake_type brake,
	output logic second_function_select,
	output dbss_pkg::dbss_tune_type tuning_select
);
	import dbss_pkg::*;

	localparam logic [4:0] VOLT_RST = LARGE_RATING ? `DBSS_VOLT_LARGE : `DBSS_VOLT_SMALL;

	dbss_state_type st_ff;
	dbss_state_type nxt_st;
	logic [7:0] mem_rdata;
	logic [3:0] mem_rd_idx;
	logic mem_wr_en;
	logic apb_wr;
	logic term_acc;
	logic [15:0] thr;
	logic hit;
	logic ext_req;
	logic dur_zero;
	logic dur_held;
	dbss_kind_type kind_t;
	dbss_kind_type kind_h;

	function automatic logic is_term(input logic [7:0] a);
		is_term = a >= `DBSS_OFS_TERM0 && a <= `DBSS_OFS_TERM_LAST && a[1:0] == 2'b00;
	endfunction

	function automatic logic [3:0] term_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - `DBSS_OFS_TERM0;
		term_idx = d[5:2];
	endfunction

	function automatic dbss_kind_type pick_kind(input dbss_ctrl_type c, input logic m,
		input logic p, input logic held);
		unique case (c)
			CTRL_VEC: pick_kind = p ? KIND_SERVO : KIND_ZERO;
			CTRL_SLV: pick_kind = (held || m) ? KIND_ZERO : KIND_DC;
			CTRL_VF, CTRL_AMF: pick_kind = KIND_DC;
		endcase
	endfunction

	dbss_term_mem u_mem
	(
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(mem_wr_en),
		.wr_idx(term_idx(paddr)),
		.wr_data(pwdata[7:0]),
		.rd_idx(mem_rd_idx),
		.rd_data(mem_rdata)
	);

	assign term_acc = psel && is_term(paddr);
	assign apb_wr = psel && penable && pwrite && st_ff.pready;
	assign mem_wr_en = apb_wr && term_acc;
	// Terminal register reads and writes borrow the port; the scan resumes after
	assign mem_rd_idx = term_acc ? term_idx(paddr) : st_ff.scan_idx;

	// unwritten default drops under vector control
	assign thr = (st_ff.bfreq == `DBSS_BFREQ_SPECIAL) ? st_ff.sfreq :
		(!st_ff.bfreq_wr && st_ff.ctrl == CTRL_VEC) ? `DBSS_BFREQ_VEC : st_ff.bfreq;
	assign hit = drive.decel && drive.out_freq <= thr;
	// request from any terminal coded 13
	assign ext_req = |(st_ff.x13_map & st_ff.term_s);
	assign dur_zero = st_ff.dur == 14'h0000;
	assign dur_held = st_ff.dur == `DBSS_BDUR_HELD;
	assign kind_t = pick_kind(st_ff.ctrl, st_ff.method, st_ff.pre, 1'b0);
	assign kind_h = pick_kind(st_ff.ctrl, st_ff.method, st_ff.pre, 1'b1);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.term_m = term_pins;
		nxt_st.term_s = st_ff.term_m;
		nxt_st.rt_m = second_fn_pin;
		nxt_st.rt_s = st_ff.rt_m;
		nxt_st.enc_m = encoder_fitted;
		nxt_st.enc_s = st_ff.enc_m;

		// Terminal function scan, one terminal per cycle
		nxt_st.rd_scan = !term_acc;
		nxt_st.rd_idx = mem_rd_idx;
		if (!term_acc)
			nxt_st.scan_idx = (st_ff.scan_idx == 4'(`DBSS_NTERM - 1)) ? 4'h0 : st_ff.scan_idx + 4'h1;
		if (st_ff.rd_scan && st_ff.rd_idx < 4'(`DBSS_NTERM))
		begin
			nxt_st.x13_map[st_ff.rd_idx] = mem_rdata == `DBSS_FN_BRAKE_REQ;
			nxt_st.rt_map[st_ff.rd_idx] = mem_rdata == `DBSS_FN_SECOND;
		end

		// APB: one wait state, answer registered
		if (st_ff.pready)
		begin
			nxt_st.pready = 1'b0;
			nxt_st.pslverr = 1'b0;
		end
		else if (psel && penable)
		begin
			nxt_st.pready = 1'b1;
			nxt_st.pslverr = 1'b0;
			nxt_st.prdata = 32'h00000000;
			if (term_acc)
				nxt_st.prdata[7:0] = mem_rdata;
			else
			begin
				unique case (paddr)
					`DBSS_OFS_CTRL: nxt_st.prdata[5:0] = {st_ff.pre, st_ff.method, 2'b00, st_ff.ctrl};
					// Special code reads back as written, else the threshold in use
					`DBSS_OFS_BFREQ: nxt_st.prdata[15:0] =
						(st_ff.bfreq == `DBSS_BFREQ_SPECIAL) ? st_ff.bfreq : thr;
					`DBSS_OFS_SFREQ: nxt_st.prdata[15:0] = st_ff.sfreq;
					`DBSS_OFS_BDUR: nxt_st.prdata[13:0] = st_ff.dur;
					`DBSS_OFS_VOLT: nxt_st.prdata[4:0] = st_ff.volt;
					`DBSS_OFS_TUNE: nxt_st.prdata[9:0] = {st_ff.tune2, 6'h00, st_ff.tune1};
					`DBSS_OFS_STAT: nxt_st.prdata[8:0] = {st_ff.enc_s, st_ff.second_fn, ext_req,
						st_ff.tune_out, st_ff.seq, st_ff.brake.kind};
					default: nxt_st.pslverr = 1'b1;
				endcase
			end
		end

		if (apb_wr && !term_acc)
		begin
			unique case (paddr)
				`DBSS_OFS_CTRL:
				begin
					nxt_st.ctrl = dbss_ctrl_type'(pwdata[1:0]);
					nxt_st.method = pwdata[`DBSS_CTRL_METHOD_BIT];
					if (st_ff.enc_s)
						nxt_st.pre = pwdata[`DBSS_CTRL_PRE_BIT];
				end
				`DBSS_OFS_BFREQ:
				begin
					nxt_st.bfreq = pwdata[15:0];
					nxt_st.bfreq_wr = 1'b1;
				end
				`DBSS_OFS_SFREQ: nxt_st.sfreq = pwdata[15:0];
				`DBSS_OFS_BDUR:
					// only 0..10 s or the held code
					if (pwdata[13:0] <= `DBSS_BDUR_MAX || pwdata[13:0] == `DBSS_BDUR_HELD)
						nxt_st.dur = pwdata[13:0];
				`DBSS_OFS_VOLT:
					if (pwdata[4:0] <= `DBSS_VOLT_MAX)
						nxt_st.volt = pwdata[4:0];
				`DBSS_OFS_TUNE:
				begin
					// code 3 is not a tuning mode
					if (pwdata[1:0] != 2'b11)
						nxt_st.tune1 = dbss_tune_type'(pwdata[1:0]);
					if (pwdata[9:8] != 2'b11)
						nxt_st.tune2 = dbss_tune_type'(pwdata[9:8]);
				end
				default: nxt_st.ctrl = st_ff.ctrl;
			endcase
		end

		// terminal code 3 overrides the dedicated pin
		nxt_st.second_fn = (st_ff.rt_map != 12'h000) ? |(st_ff.rt_map & st_ff.term_s) : st_ff.rt_s;
		// second tuning only with second function
		nxt_st.tune_out = st_ff.second_fn ? st_ff.tune2 : st_ff.tune1;

		unique case (st_ff.seq)
			SEQ_RUN:
				if (hit)
				begin
					if (dur_zero)
						nxt_st.seq = SEQ_DONE;
					else if (dur_held)
						nxt_st.seq = (ext_req && !(kind_h == KIND_DC && st_ff.volt == 5'h00)) ?
							SEQ_HELD : SEQ_DONE;
					else if (kind_t == KIND_DC && st_ff.volt == 5'h00)
						nxt_st.seq = SEQ_DONE;
					else
					begin
						nxt_st.seq = SEQ_TIMED;
						nxt_st.tick = 21'h000000;
						nxt_st.remain = st_ff.dur[6:0];
					end
				end
			SEQ_TIMED:
			begin
				nxt_st.tick = st_ff.tick + 21'h000001;
				if (st_ff.tick == 21'(TICK_CYCLES - 1))
				begin
					nxt_st.tick = 21'h000000;
					nxt_st.remain = st_ff.remain - 7'h01;
					if (st_ff.remain <= 7'h01)
						nxt_st.seq = SEQ_DONE;
				end
			end
			SEQ_HELD:
				if (!ext_req || !dur_held)
					nxt_st.seq = SEQ_DONE;
			SEQ_DONE:
				if (dur_held && ext_req && !(kind_h == KIND_DC && st_ff.volt == 5'h00))
					nxt_st.seq = SEQ_HELD;
				else if (!drive.decel)
					nxt_st.seq = SEQ_RUN;
		endcase

		nxt_st.brake.active = nxt_st.seq == SEQ_TIMED || nxt_st.seq == SEQ_HELD;
		nxt_st.brake.coast = nxt_st.seq == SEQ_DONE;
		nxt_st.brake.kind = (nxt_st.seq == SEQ_TIMED) ? kind_t :
			(nxt_st.seq == SEQ_HELD) ? kind_h : KIND_NONE;
		// Voltage unused by zero speed and servo lock
		nxt_st.brake.volt = (nxt_st.brake.kind == KIND_DC) ? st_ff.volt : 5'h00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= '0;
			st_ff.ctrl <= CTRL_VF;
			st_ff.bfreq <= `DBSS_BFREQ_RST;
			st_ff.sfreq <= `DBSS_SFREQ_RST;
			st_ff.dur <= `DBSS_BDUR_RST;
			st_ff.volt <= VOLT_RST;
			st_ff.seq <= SEQ_RUN;
			st_ff.rd_idx <= 4'hF;
		end
		else
			st_ff <= nxt_st;
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign brake = st_ff.brake;
	assign second_function_select = st_ff.second_fn;
	assign tuning_select = st_ff.tune_out;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_start_timed: assert property (st_ff.seq == SEQ_RUN && hit && !dur_zero && !dur_held
		&& !(kind_t == KIND_DC && st_ff.volt == 5'h00) |=> brake.active && st_ff.seq == SEQ_TIMED)
		else $error("brake did not start at threshold");
	chk_timed_end: assert property (st_ff.seq == SEQ_TIMED && st_ff.remain == 7'h01
		&& st_ff.tick == 21'(TICK_CYCLES - 1) |=> !brake.active && brake.coast)
		else $error("timed brake did not end");
	chk_zero_coast: assert property (st_ff.seq == SEQ_RUN && hit && dur_zero
		|=> !brake.active ##1 !brake.active)
		else $error("brake with zero duration");
	chk_held_release: assert property (st_ff.seq == SEQ_HELD && !ext_req |=> !brake.active)
		else $error("held brake not released");
	chk_held_zero: assert property (st_ff.seq == SEQ_HELD && st_ff.ctrl == CTRL_SLV
		&& $stable(st_ff.ctrl) |-> brake.kind == KIND_ZERO)
		else $error("held brake not zero speed");
	chk_vector_kind: assert property (brake.active && $past(st_ff.ctrl) == CTRL_VEC
		|-> brake.kind == ($past(st_ff.pre) ? KIND_SERVO : KIND_ZERO))
		else $error("vector brake kind wrong");
	chk_slv_kind: assert property (st_ff.seq == SEQ_TIMED && $past(st_ff.ctrl) == CTRL_SLV
		&& $past(st_ff.seq) == SEQ_TIMED |-> brake.kind == ($past(st_ff.method) ? KIND_ZERO : KIND_DC))
		else $error("sensorless brake kind wrong");
	chk_inj_volt: assert property (brake.kind == KIND_DC |-> brake.volt == $past(st_ff.volt)
		&& brake.volt != 5'h00)
		else $error("injection voltage wrong");
	chk_pre_lock: assert property (apb_wr && paddr == `DBSS_OFS_CTRL && !st_ff.enc_s
		|=> $stable(st_ff.pre))
		else $error("pre-excitation written without encoder");
	chk_tune_sel: assert property (second_function_select ##1 second_function_select
		&& $stable(st_ff.tune2) |-> tuning_select == st_ff.tune2)
		else $error("second tuning not applied");
	chk_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");

	cov_timed: cover property (st_ff.seq == SEQ_TIMED ##1 st_ff.seq == SEQ_DONE);
	cov_held: cover property (st_ff.seq == SEQ_HELD ##1 !ext_req);
	cov_servo: cover property (brake.active && brake.kind == KIND_SERVO);
	cov_coast: cover property (st_ff.seq == SEQ_RUN && hit && dur_zero);
endmodule

// ### sim/dbss_drive_model.sv
`timescale 1ns/1ps
module dbss_drive_model
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench command
	input wire logic dec_en,
	input wire logic [15:0] floor_f,
	// Drive status
	output dbss_pkg::dbss_drive_type drive
);
	import dbss_pkg::*;
	// Ramps 0.1 Hz a cycle; a raised floor stalls the ramp like a heavy load
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drive <= {1'b0, 16'h0258};
		end
		else if (!dec_en)
		begin
			drive <= {1'b0, 16'h0258};
		end
		else if (drive.out_freq > floor_f + 16'h000A)
		begin
			drive <= {1'b1, drive.out_freq - 16'h000A};
		end
		else
		begin
			drive <= {1'b1, floor_f};
		end
	end
endmodule

// ### sim/dbss_top_tb.sv
`timescale 1ns/1ps
`include "dbss_defs.svh"
module dbss_top_tb;
	import dbss_pkg::*;
	localparam int TC = 10;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dbss_drive_type drive;
	logic [11:0] term_pins = 12'h000;
	logic second_fn_pin = 1'b0;
	logic encoder_fitted = 1'b0;
	dbss_brake_type brake;
	logic second_function_select;
	dbss_tune_type tuning_select;
	logic dec_en = 1'b0;
	logic [15:0] floor_f = 16'h0000;
	int n_fail = 0;
	int samples_checked = 0;
	logic [31:0] q;
	logic e;

	always #25 pclk = ~pclk;

	dbss_top #(.TICK_CYCLES(TC), .LARGE_RATING(1'b0)) i_dbss_top
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drive(drive), .term_pins(term_pins),
		.second_fn_pin(second_fn_pin), .encoder_fitted(encoder_fitted),
		.brake(brake), .second_function_select(second_function_select),
		.tuning_select(tuning_select)
	);

	dbss_drive_model i_dbss_drive_model
	(
		.pclk(pclk), .presetn(presetn), .dec_en(dec_en), .floor_f(floor_f),
		.drive(drive)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One wait state always; a hang is left to the watchdog
		chk(n, 2);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Decelerate, then judge entry, kind, length and release; cyc 0 means held
	task automatic stop_run(input logic [8:0] exp, input int cyc, input int thr);
		int n;
		dec_en <= 1'b1;
		n = 0;
		while (brake.active !== 1'b1 && n < 150)
		begin
			@(posedge pclk);
			n++;
		end
		chk(brake, exp);
		if (exp[8])
		begin
			chk(drive.out_freq <= thr && drive.out_freq + 30 >= thr, 1'b1);
			n = 0;
			if (cyc == 0)
			begin
				tick(30);
				chk(brake.active, 1'b1);
				term_pins <= 12'h000;
			end
			while (brake.active === 1'b1 && n < 1200)
			begin
				@(posedge pclk);
				n++;
			end
			if (cyc == 0)
				chk(n > 30 + 6, 1'b0);
			else
				chk(n >= cyc && n <= cyc + 1, 1'b1);
			tick(1);
			chk({brake.active, brake.coast}, 2'b01);
		end
		dec_en <= 1'b0;
		tick(6);
		$display("stop run done t=%0t", $time);
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		tick(6);
		presetn <= 1'b1;
	endtask

	initial
	begin
		#500000;
		n_fail++;
		end_sim;
	end

	initial
	begin
		do_reset;
		rd(`DBSS_OFS_CTRL, 32'h0);
		rd(`DBSS_OFS_BFREQ, 32'h012C);
		rd(`DBSS_OFS_SFREQ, 32'h0032);
		rd(`DBSS_OFS_BDUR, 32'h0005);
		rd(`DBSS_OFS_VOLT, 32'h0004);
		apb(1'b0, 8'h20, 32'h0);
		chk(e, 1'b1);
		apb(1'b1, 8'h20, 32'h5);
		chk(e, 1'b1);
		stop_run({1'b1, 1'b0, KIND_DC, 5'h04}, 5 * TC, 300);
		wr(`DBSS_OFS_BDUR, 32'h0001);
		wr(`DBSS_OFS_BDUR, 32'h0065);
		rd(`DBSS_OFS_BDUR, 32'h0001);
		stop_run({1'b1, 1'b0, KIND_DC, 5'h04}, TC, 300);
		wr(`DBSS_OFS_BDUR, 32'h0000);
		stop_run({1'b0, 1'b1, KIND_NONE, 5'h00}, 0, 300);
		wr(`DBSS_OFS_BDUR, 32'h0005);
		wr(`DBSS_OFS_VOLT, 32'h001F);
		wr(`DBSS_OFS_VOLT, 32'h0000);
		rd(`DBSS_OFS_VOLT, 32'h0000);
		stop_run({1'b0, 1'b1, KIND_NONE, 5'h00}, 0, 300);
		wr(`DBSS_OFS_VOLT, 32'h001E);
		wr(`DBSS_OFS_BFREQ, 32'h270F);
		rd(`DBSS_OFS_BFREQ, 32'h270F);
		stop_run({1'b1, 1'b0, KIND_DC, 5'h1E}, 5 * TC, 50);
		$display("timed braking done");
		wr(`DBSS_OFS_BFREQ, 32'h0032);
		wr(`DBSS_OFS_CTRL, 32'h0012);
		stop_run({1'b1, 1'b0, KIND_ZERO, 5'h00}, 5 * TC, 50);
		wr(`DBSS_OFS_CTRL, 32'h0002);
		stop_run({1'b1, 1'b0, KIND_DC, 5'h1E}, 5 * TC, 50);
		// Advanced flux ignores the method bit
		wr(`DBSS_OFS_CTRL, 32'h0011);
		stop_run({1'b1, 1'b0, KIND_DC, 5'h1E}, 5 * TC, 50);
		wr(`DBSS_OFS_CTRL, 32'h0002);
		wr(`DBSS_OFS_BDUR, 32'h22B8);
		wr(8'h48, 32'h000D);
		tick(20);
		term_pins <= 12'h004;
		stop_run({1'b1, 1'b0, KIND_ZERO, 5'h00}, 0, 50);
		$display("held braking done");
		wr(`DBSS_OFS_CTRL, 32'h0023);
		rd(`DBSS_OFS_CTRL, 32'h0003);
		do_reset;
		encoder_fitted <= 1'b1;
		tick(4);
		wr(`DBSS_OFS_CTRL, 32'h0023);
		rd(`DBSS_OFS_CTRL, 32'h0023);
		rd(`DBSS_OFS_BFREQ, 32'h0032);
		stop_run({1'b1, 1'b0, KIND_SERVO, 5'h00}, 5 * TC, 50);
		wr(`DBSS_OFS_CTRL, 32'h0003);
		stop_run({1'b1, 1'b0, KIND_ZERO, 5'h00}, 5 * TC, 50);
		$display("vector braking done");
		for (int c = 0; c < 3; c++)
		begin
			wr(`DBSS_OFS_TUNE, 32'h0200 | c);
			tick(4);
			chk(tuning_select, c);
		end
		second_fn_pin <= 1'b1;
		tick(5);
		chk(second_function_select, 1'b1);
		chk(tuning_select, TUNE_OBSERVER);
		wr(`DBSS_OFS_TUNE, 32'h0102);
		tick(4);
		chk(tuning_select, TUNE_START);
		wr(8'h54, 32'h0003);
		tick(20);
		chk(second_function_select, 1'b0);
		chk(tuning_select, TUNE_OBSERVER);
		term_pins <= 12'h020;
		tick(5);
		chk(second_function_select, 1'b1);
		rd(`DBSS_OFS_STAT, 32'h0190);
		wr(`DBSS_OFS_TUNE, 32'h0303);
		rd(`DBSS_OFS_TUNE, 32'h0102);
		$display("tuning select done");
		end_sim;
	end
endmodule
